// ===== include/smsf_pkg.sv
package smsf_pkg;

  // register byte offsets
  localparam logic [7:0] SMSF_OFF_WINDOW   = 8'h00;
  localparam logic [7:0] SMSF_OFF_COUNT    = 8'h04;
  localparam logic [7:0] SMSF_OFF_STATUS   = 8'h08;
  localparam logic [7:0] SMSF_OFF_MASK     = 8'h0C;
  localparam logic [7:0] SMSF_OFF_CTRL     = 8'h10;
  localparam logic [7:0] SMSF_OFF_THERM    = 8'h14;
  localparam logic [7:0] SMSF_OFF_FOLLOW   = 8'h18;
  localparam logic [7:0] SMSF_OFF_FUNC     = 8'h1C;
  localparam logic [7:0] SMSF_OFF_LOWLIM   = 8'h20;
  localparam logic [7:0] SMSF_OFF_UPLIM    = 8'h24;

  // reset values
  localparam logic [31:0] SMSF_RST_WINDOW  = 32'h0000_0064;
  localparam logic [31:0] SMSF_RST_COUNT   = 32'h0000_0003;
  localparam logic [31:0] SMSF_RST_STATUS  = 32'h0000_0000;
  localparam logic [31:0] SMSF_RST_ZERO    = 32'h0000_0000;

  // status word bit positions
  localparam int SMSF_B_THERM   = 0;
  localparam int SMSF_B_FOLLOW  = 1;
  localparam int SMSF_B_FUNC    = 2;
  localparam int SMSF_B_BRAKE   = 3;
  localparam int SMSF_B_INPOS   = 4;
  localparam int SMSF_B_SPDUP   = 5;
  localparam int SMSF_B_SLOW    = 6;
  localparam int SMSF_B_LIMIT   = 7;
  localparam int SMSF_B_OVRD    = 14;

  // sticky, write-one-to-clear bits of the status word
  localparam logic [31:0] SMSF_STICKY_MASK = 32'h0000_008F;
  // bits that follow the latest sample
  localparam logic [31:0] SMSF_LIVE_MASK   = 32'h0000_0070;

  // control register: operating mode field
  localparam int SMSF_CTRL_MODE_LSB = 0;
  localparam int SMSF_CTRL_MODE_W   = 2;
  localparam logic [1:0] SMSF_MODE_POS = 2'h0;
  localparam logic [1:0] SMSF_MODE_VEL = 2'h1;
  localparam logic [1:0] SMSF_MODE_TRQ = 2'h2;

endpackage

// ===== design/smsf_settle.sv
`timescale 1ns/1ps
module smsf_settle
  import smsf_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        tick_i,
  // sample condition and target count
  input  wire logic        hit_i,
  input  wire logic [31:0] target_i,
  // result
  output logic             settled_o
);

  // the run counter must fit beside the 32-bit target count
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("smsf_settle: CNT_W must be 2..32");
  end

  logic [CNT_W-1:0] run_q;
  logic [CNT_W-1:0] run_d;
  logic [31:0]      run_ext;
  logic             settled_d;
  wire              at_max = &run_q;

  // saturate so a long stay in the window never wraps back to zero
  assign run_d = !hit_i ? '0 : at_max ? run_q : run_q + 1'b1;
  assign run_ext = 32'(run_d);
  assign settled_d = hit_i && (run_ext >= target_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q     <= '0;
      settled_o <= 1'b0;
    end else if (ce_i && tick_i) begin
      run_q     <= run_d;
      settled_o <= settled_d;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  settle_count_a: assert property (ce_i && tick_i && hit_i
    |=> settled_o == (32'(run_q) >= $past(target_i)))
    else $error("settled against wrong count");
  miss_reset_a: assert property (ce_i && tick_i && !hit_i
    |=> run_q == '0 && !settled_o) else $error("miss kept run");
  cover_settle_c: cover property ($rose(settled_o));

endmodule

// ===== design/smsf_top.sv
`timescale 1ns/1ps
// Function
// - in position modes a sample is in window when |actual-target| < window.
// - in-position is set only after that many consecutive in-window samples.
// - in velocity modes the same status means at-velocity, same counting.
// - the in-position or at-velocity result is bit 4 of the status word.
// - bit 0 is set when motor thermal load exceeds its programmed limit.
// - bit 1 is set when follow deviation exceeds a nonzero maximum.
// - bit 2 is set when function deviation exceeds a nonzero maximum.
// - bit 3 is set when the brake resistor overload is reported.
// - bit 5 is set when the signed velocity falls from one sample to the next.
// - the speeding-up flag follows the signed compare for negative velocity.
// - bit 6 is set on a signed velocity rise; bits 5 and 6 are both clear when it is unchanged.
// - bit 7 is set when actual position passes a nonzero low or high soft limit.
// - past a nonzero upper soft limit the motor is stopped and made passive.
// - bit 14 keeps the motor active past a limit and self-clears inside.
module smsf_top
  import smsf_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // control loop sample tick
  input  wire logic        sample_tick_i,
  // quantities from the control loop
  input  wire logic [31:0] actual_position_i,
  input  wire logic [31:0] target_position_i,
  input  wire logic [31:0] measured_velocity_i,
  input  wire logic [31:0] target_velocity_i,
  input  wire logic [31:0] motor_thermal_load_i,
  input  wire logic [31:0] follow_deviation_i,
  input  wire logic [31:0] function_deviation_i,
  input  wire logic        brake_resistor_overload_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // drive outputs
  output logic             motor_passive_o,
  output logic             irq_o
);

  // the run counter must fit beside the 32-bit count register
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("smsf_top: CNT_W must be 2..32");
  end

  function automatic logic [32:0] abs_diff(input logic [31:0] a,
                                           input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    abs_diff = d[32] ? 33'(-d) : 33'(d);
  endfunction

  function automatic logic reg_at(input logic [7:0] a,
                                  input logic [7:0] off);
    reg_at = (a == off);
  endfunction

  // registers
  logic [31:0] target_window_q;
  logic [31:0] target_sample_count_q;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [31:0] ctrl_q;
  logic [31:0] thermal_load_limit_q;
  logic [31:0] follow_deviation_max_q;
  logic [31:0] function_deviation_max_q;
  logic [31:0] lower_soft_limit_q;
  logic [31:0] upper_soft_limit_q;
  logic [31:0] prev_velocity_q;
  logic        settled;

  // apb decode
  wire         setup    = psel_i && !penable_i;
  wire         apb_wr   = psel_i && penable_i && pready_o && pwrite_i;
  wire         hit_win  = reg_at(paddr_i, SMSF_OFF_WINDOW);
  wire         hit_cnt  = reg_at(paddr_i, SMSF_OFF_COUNT);
  wire         hit_stat = reg_at(paddr_i, SMSF_OFF_STATUS);
  wire         hit_mask = reg_at(paddr_i, SMSF_OFF_MASK);
  wire         hit_ctrl = reg_at(paddr_i, SMSF_OFF_CTRL);
  wire         hit_thrm = reg_at(paddr_i, SMSF_OFF_THERM);
  wire         hit_flw  = reg_at(paddr_i, SMSF_OFF_FOLLOW);
  wire         hit_fnc  = reg_at(paddr_i, SMSF_OFF_FUNC);
  wire         hit_llim = reg_at(paddr_i, SMSF_OFF_LOWLIM);
  wire         hit_ulim = reg_at(paddr_i, SMSF_OFF_UPLIM);
  wire         mapped   = hit_win | hit_cnt | hit_stat | hit_mask | hit_ctrl
                        | hit_thrm | hit_flw | hit_fnc | hit_llim | hit_ulim;
  wire         wr_stat  = apb_wr && hit_stat;
  wire [31:0]  rd_mux   =
      hit_win  ? target_window_q          :
      hit_cnt  ? target_sample_count_q    :
      hit_stat ? status_q                 :
      hit_mask ? mask_q                   :
      hit_ctrl ? ctrl_q                   :
      hit_thrm ? thermal_load_limit_q     :
      hit_flw  ? follow_deviation_max_q   :
      hit_fnc  ? function_deviation_max_q :
      hit_llim ? lower_soft_limit_q       :
      hit_ulim ? upper_soft_limit_q       : 32'h0000_0000;

  // operating mode
  wire [1:0]   mode     = ctrl_q[SMSF_CTRL_MODE_LSB +: SMSF_CTRL_MODE_W];
  wire         mode_vel = (mode == SMSF_MODE_VEL);
  wire         mode_pos = (mode == SMSF_MODE_POS);
  wire         tick     = ce_i && sample_tick_i;

  // window test; torque and unused codes never count as in window
  wire [32:0]  pos_err  = abs_diff(actual_position_i, target_position_i);
  wire [32:0]  vel_err  = abs_diff(measured_velocity_i, target_velocity_i);
  wire [32:0]  win_ext  = {1'b0, target_window_q};
  wire         pos_hit  = mode_pos && (pos_err < win_ext);
  wire         vel_hit  = mode_vel && (vel_err < win_ext);
  wire         in_win   = pos_hit || vel_hit;

  // fault conditions
  wire thermal_load_fault = motor_thermal_load_i > thermal_load_limit_q;
  wire follow_fault = (follow_deviation_max_q != 32'h0000_0000)
                   && (follow_deviation_i > follow_deviation_max_q);
  wire function_fault = (function_deviation_max_q != 32'h0000_0000)
                   && (function_deviation_i > function_deviation_max_q);
  // signed compare keeps the legacy meaning for negative velocity
  wire speeding_up_flag = $signed(measured_velocity_i)
                        < $signed(prev_velocity_q);
  wire slowing_down_flag = $signed(measured_velocity_i)
                         > $signed(prev_velocity_q);
  wire over_upper = (upper_soft_limit_q != 32'h0000_0000)
      && ($signed(actual_position_i) > $signed(upper_soft_limit_q));
  wire under_lower = (lower_soft_limit_q != 32'h0000_0000)
      && ($signed(actual_position_i) < $signed(lower_soft_limit_q));
  wire soft_limit_fault = over_upper || under_lower;
  wire soft_limit_override = status_q[SMSF_B_OVRD];

  // status word next value
  logic [31:0] ev_set;
  logic [31:0] live_new;
  always_comb begin
    ev_set = 32'h0000_0000;
    ev_set[SMSF_B_THERM]  = thermal_load_fault;
    ev_set[SMSF_B_FOLLOW] = follow_fault;
    ev_set[SMSF_B_FUNC]   = function_fault;
    ev_set[SMSF_B_BRAKE]  = brake_resistor_overload_i;
    ev_set[SMSF_B_LIMIT]  = soft_limit_fault;
    live_new = 32'h0000_0000;
    live_new[SMSF_B_INPOS] = settled;
    live_new[SMSF_B_SPDUP] = speeding_up_flag;
    live_new[SMSF_B_SLOW]  = slowing_down_flag;
  end

  wire [31:0] w1c      = wr_stat ? (pwdata_i & SMSF_STICKY_MASK)
                                 : 32'h0000_0000;
  // a fault seen in the cycle of its clear stays set
  wire [31:0] sticky_d = ((status_q & ~w1c) | (tick ? ev_set
                        : 32'h0000_0000)) & SMSF_STICKY_MASK;
  wire [31:0] live_d   = (tick ? live_new : status_q) & SMSF_LIVE_MASK;
  // software setting the override wins over the self-clear
  wire        ovrd_d   = wr_stat ? pwdata_i[SMSF_B_OVRD]
                       : (tick && !soft_limit_fault) ? 1'b0
                       : soft_limit_override;
  wire [31:0] status_d = sticky_d | live_d
                       | (32'(ovrd_d) << SMSF_B_OVRD);
  wire        passive_d = tick ? (soft_limit_fault && !soft_limit_override)
                               : motor_passive_o;

  smsf_settle #(
    .CNT_W (CNT_W)
  ) u_settle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_i    (sample_tick_i),
    .hit_i     (in_win),
    .target_i  (target_sample_count_q),
    .settled_o (settled)
  );

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_window_q          <= SMSF_RST_WINDOW;
      target_sample_count_q    <= SMSF_RST_COUNT;
      mask_q                   <= SMSF_RST_ZERO;
      ctrl_q                   <= SMSF_RST_ZERO;
      thermal_load_limit_q     <= SMSF_RST_ZERO;
      follow_deviation_max_q   <= SMSF_RST_ZERO;
      function_deviation_max_q <= SMSF_RST_ZERO;
      lower_soft_limit_q       <= SMSF_RST_ZERO;
      upper_soft_limit_q       <= SMSF_RST_ZERO;
    end else if (ce_i && apb_wr) begin
      if (hit_win)  target_window_q          <= pwdata_i;
      if (hit_cnt)  target_sample_count_q    <= pwdata_i;
      if (hit_mask) mask_q                   <= pwdata_i;
      if (hit_ctrl) ctrl_q                   <= pwdata_i & 32'h0000_0003;
      if (hit_thrm) thermal_load_limit_q     <= pwdata_i;
      if (hit_flw)  follow_deviation_max_q   <= pwdata_i;
      if (hit_fnc)  function_deviation_max_q <= pwdata_i;
      if (hit_llim) lower_soft_limit_q       <= pwdata_i;
      if (hit_ulim) upper_soft_limit_q       <= pwdata_i;
    end
  end

  // status, sample history and outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q        <= SMSF_RST_STATUS;
      prev_velocity_q <= SMSF_RST_ZERO;
      motor_passive_o <= 1'b0;
      irq_o           <= 1'b0;
    end else if (ce_i) begin
      status_q        <= status_d;
      if (sample_tick_i) prev_velocity_q <= measured_velocity_i;
      motor_passive_o <= passive_d;
      irq_o           <= |(status_q & mask_q);
    end
  end

  // no wait state: data captured in setup, answer in first access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o  <= setup;
      pslverr_o <= setup && !mapped;
      if (setup) prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  apb_answer_a: assert property (ce_i && setup |=> pready_o ##1
    (!ce_i || !pready_o)) else $error("apb answer timing wrong");
  inpos_mode_a: assert property ($rose(status_q[SMSF_B_INPOS])
    |-> $past(mode) != SMSF_MODE_TRQ) else $error("inpos in torque");
  thermal_set_a: assert property (tick && thermal_load_fault
    |=> status_q[SMSF_B_THERM]) else $error("thermal bit missed");
  follow_zero_a: assert property ($rose(status_q[SMSF_B_FOLLOW])
    |-> $past(follow_deviation_max_q) != 32'h0000_0000)
    else $error("follow set with zero max");
  follow_set_a: assert property (tick && follow_fault
    |=> status_q[SMSF_B_FOLLOW]) else $error("follow bit missed");
  func_zero_a: assert property ($rose(status_q[SMSF_B_FUNC])
    |-> $past(function_deviation_max_q) != 32'h0000_0000)
    else $error("function set with zero max");
  func_set_a: assert property (tick && function_fault
    |=> status_q[SMSF_B_FUNC]) else $error("function bit missed");
  brake_set_a: assert property (tick && brake_resistor_overload_i
    |=> status_q[SMSF_B_BRAKE]) else $error("brake bit missed");
  speed_flags_a: assert property (tick
    |=> status_q[SMSF_B_SPDUP]
    == ($signed(prev_velocity_q) < $signed($past(prev_velocity_q))))
    else $error("speed flag wrong");
  slow_flag_a: assert property (tick && slowing_down_flag
    |=> status_q[SMSF_B_SLOW] && !status_q[SMSF_B_SPDUP])
    else $error("slow flag wrong");
  limit_set_a: assert property (tick && under_lower
    |=> status_q[SMSF_B_LIMIT]) else $error("limit bit missed");
  upper_set_a: assert property (tick && over_upper
    |=> status_q[SMSF_B_LIMIT]) else $error("upper limit bit missed");
  limit_zero_a: assert property ($rose(status_q[SMSF_B_LIMIT])
    |-> $past(upper_soft_limit_q) != 32'h0000_0000
    || $past(lower_soft_limit_q) != 32'h0000_0000)
    else $error("limit set with both limits off");
  passive_stop_a: assert property (tick && over_upper
    && !soft_limit_override |=> motor_passive_o ##1 (motor_passive_o
    || $past(tick))) else $error("no stop past limit");
  passive_hold_a: assert property (ce_i && !tick
    |=> $stable(motor_passive_o)) else $error("passive moved off tick");
  ovrd_clear_a: assert property (tick && !soft_limit_fault
    && !wr_stat |=> !status_q[SMSF_B_OVRD]) else $error("override kept");
  pos_miss_a: assert property (tick && mode_pos && pos_err >= win_ext
    |=> !settled) else $error("position window not strict");
  vel_miss_a: assert property (tick && mode_vel && vel_err >= win_ext
    |=> !settled) else $error("velocity window not strict");
  live_hold_a: assert property (ce_i && !tick
    |=> $stable(status_q[SMSF_B_INPOS])) else $error("inpos moved off tick");
  unmapped_err_a: assert property (ce_i && setup && !mapped
    |=> pready_o && pslverr_o) else $error("unmapped not refused");
  cfg_write_a: assert property (ce_i && apb_wr && hit_cnt
    |=> target_sample_count_q == $past(pwdata_i))
    else $error("count write lost");
  // clock enable low must freeze every flop, the bus answer included
  ce_freeze_a: assert property (!ce_i |=> $stable(status_q)
    && $stable(motor_passive_o) && $stable(pready_o) && $stable(irq_o))
    else $error("state moved with enable low");
  irq_level_a: assert property (ce_i |=> irq_o ==
    |($past(status_q) & $past(mask_q))) else $error("irq level wrong");

  cover_inpos_c: cover property ($rose(status_q[SMSF_B_INPOS]));
  cover_passive_c: cover property ($rose(motor_passive_o));
  cover_irq_c: cover property ($rose(irq_o));
  cover_w1c_c: cover property (wr_stat ##1 status_q == 32'h0000_0000);

endmodule

// ===== sim/smsf_host.sv
`timescale 1ns/1ps
// host side: one apb transfer at a time, request held until pready
module smsf_host (
  // clock
  input  wire logic        clk_i,
  // answer from the slave
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  // request to the slave
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  logic [31:0] rdata;
  logic        rerr;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // no limit here: a dead slave is caught by the bench watchdog
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    rdata = prdata_i;
    rerr  = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// ===== sim/tb_servo_motion_status_flags.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb_servo_motion_status_flags
  import smsf_pkg::*;
;
  typedef struct packed {
    logic [7:0] lim;
    logic [7:0] load;
    logic [7:0] fol;
    logic [7:0] fnc;
    logic       brk;
    logic [7:0] ex;
  } smsf_row_s;

  // thermal limit stays 10; lim feeds both deviation maxima
  smsf_row_s   rows [6] = '{'{8'h0A, 8'h0B, 8'h00, 8'h00, 1'b0, 8'h01},
                            '{8'h0A, 8'h0A, 8'h0A, 8'h0A, 1'b0, 8'h00},
                            '{8'h0A, 8'h00, 8'h0B, 8'h00, 1'b0, 8'h02},
                            '{8'h0A, 8'h00, 8'h00, 8'h0B, 1'b0, 8'h04},
                            '{8'h00, 8'h00, 8'h63, 8'h63, 1'b0, 8'h00},
                            '{8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 8'h08}};
  logic [31:0] vs   [7] = '{32'h0000_000A, 32'h0000_0004, 32'h0000_000A,
                            32'h0000_000A, 32'hFFFF_FFFE, 32'hFFFF_FFFB,
                            32'hFFFF_FFFE};
  logic [1:0]  ea   [7] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2};
  logic        clk_i = 1'b0;
  logic        ce = 1'b1;
  logic        rst_i = 1'b1;
  logic        tick, brk, psel, penable, pwrite;
  logic        pready, pslverr, passive, irq;
  logic [7:0]  paddr;
  logic [31:0] pos, vel, load, fol, fnc, tgt, pwdata, prdata;
  int          errors = 0;
  int          cmp_count = 0;
  wire  [31:0] r = host_i.rdata;

  always #20 clk_i = ~clk_i;

  smsf_host host_i (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  smsf_top #(.CNT_W(32)) smsf_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .sample_tick_i(tick), .actual_position_i(pos),
    .target_position_i(tgt), .measured_velocity_i(vel),
    .target_velocity_i(tgt), .motor_thermal_load_i(load),
    .follow_deviation_i(fol), .function_deviation_i(fnc),
    .brake_resistor_overload_i(brk), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .motor_passive_o(passive), .irq_o(irq));

  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_i.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    host_i.xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end
  endtask

  // position and velocity move together; the mode decides which one matters
  task automatic run(input logic [31:0] d, input int n);
    @(posedge clk_i);
    pos <= d;
    vel <= d;
    tk(n);
  endtask

  task automatic chk_st(input int b, input logic e);
    rd(SMSF_OFF_STATUS);
    `CHK(r[b], e)
  endtask

  initial begin
    {tick, brk, pos, vel, load, fol, fnc, tgt} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SMSF_OFF_WINDOW);
    `CHK(r, SMSF_RST_WINDOW)
    rd(SMSF_OFF_COUNT);
    `CHK(r, SMSF_RST_COUNT)
    rd(8'h40);
    `CHK({host_i.rerr, r}, {1'b1, 32'h0000_0000})
    wr(SMSF_OFF_COUNT, 32'h0000_0005);
    rd(SMSF_OFF_COUNT);
    `CHK(r, 32'h0000_0005)
    wr(SMSF_OFF_COUNT, SMSF_RST_COUNT);
    wr(SMSF_OFF_THERM, 32'h0000_000A);
    foreach (rows[i]) begin
      load <= 32'(rows[i].load);
      fol  <= 32'(rows[i].fol);
      fnc  <= 32'(rows[i].fnc);
      brk  <= rows[i].brk;
      wr(SMSF_OFF_FOLLOW, 32'(rows[i].lim));
      wr(SMSF_OFF_FUNC, 32'(rows[i].lim));
      wr(SMSF_OFF_STATUS, SMSF_STICKY_MASK);
      tk(1);
      rd(SMSF_OFF_STATUS);
      `CHK(r[7:0] & 8'h8F, rows[i].ex)
    end
    wr(SMSF_OFF_MASK, 32'h0000_0001);
    load <= 32'h0000_0020;
    tk(1);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(SMSF_OFF_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wr(SMSF_OFF_MASK, 32'h0000_0001);
    load <= 32'h0000_0000;
    wr(SMSF_OFF_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    run(32'h0000_03E8, 2);
    run(32'h0000_0063, 3);
    chk_st(SMSF_B_INPOS, 1'b0);
    run(32'h0000_0063, 1);
    chk_st(SMSF_B_INPOS, 1'b1);
    // a single miss must restart the count
    run(32'h0000_0064, 1);
    run(32'h0000_0063, 3);
    chk_st(SMSF_B_INPOS, 1'b0);
    run(32'h0000_0064, 6);
    chk_st(SMSF_B_INPOS, 1'b0);
    // window is measured from the target, not from zero
    tgt <= 32'h0000_03E8;
    run(32'h0000_0385, 5);
    chk_st(SMSF_B_INPOS, 1'b1);
    tgt <= 32'h0000_0000;
    wr(SMSF_OFF_CTRL, 32'(SMSF_MODE_VEL));
    run(32'h0000_03E8, 2);
    run(32'hFFFF_FF9D, 4);
    chk_st(SMSF_B_INPOS, 1'b1);
    wr(SMSF_OFF_CTRL, 32'(SMSF_MODE_TRQ));
    run(32'h0000_0000, 6);
    chk_st(SMSF_B_INPOS, 1'b0);
    wr(SMSF_OFF_CTRL, 32'(SMSF_MODE_POS));
    foreach (vs[i]) begin
      run(vs[i], 1);
      rd(SMSF_OFF_STATUS);
      `CHK(r[6:5], ea[i])
    end
    wr(SMSF_OFF_UPLIM, 32'h0000_01F4);
    wr(SMSF_OFF_STATUS, SMSF_STICKY_MASK);
    run(32'h0000_0258, 1);
    chk_st(SMSF_B_LIMIT, 1'b1);
    `CHK(passive, 1'b1)
    wr(SMSF_OFF_STATUS, 32'h0000_4080);
    run(32'h0000_0258, 1);
    chk_st(SMSF_B_OVRD, 1'b1);
    `CHK(passive, 1'b0)
    run(32'h0000_0000, 1);
    chk_st(SMSF_B_OVRD, 1'b0);
    wr(SMSF_OFF_LOWLIM, 32'hFFFF_FF00);
    wr(SMSF_OFF_STATUS, SMSF_STICKY_MASK);
    run(32'hFFFF_FED4, 1);
    chk_st(SMSF_B_LIMIT, 1'b1);
    brk  <= 1'b0;
    load <= 32'h0000_0020;
    wr(SMSF_OFF_STATUS, SMSF_STICKY_MASK);
    // a tick with the clock enable low must leave no trace
    ce   <= 1'b0;
    tk(1);
    ce   <= 1'b1;
    chk_st(SMSF_B_THERM, 1'b0);
    tk(1);
    chk_st(SMSF_B_THERM, 1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SMSF_OFF_STATUS);
    `CHK(r, SMSF_RST_STATUS)
    `CHK({passive, irq}, 2'b00)
    rd(SMSF_OFF_LOWLIM);
    `CHK(r, SMSF_RST_ZERO)
    wrap_up();
  end

  // the sequence needs under 400 cycles; fifty times that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
endmodule
